// ### hdl/sysclk_pkg.sv
// constants and types for the system clock select control block
package sysclk_pkg;
    localparam logic [3:0] SYSCLK_ADDR_OSCCTL = 4'h0;
    localparam logic [3:0] SYSCLK_ADDR_CLOCK_DIVIDER_REG = 4'h1;
    localparam logic [3:0] SYSCLK_ADDR_UNLOCK = 4'h2;
    localparam logic [3:0] SYSCLK_ADDR_PINSEL = 4'h3;
    localparam logic [3:0] SYSCLK_ADDR_STATUS = 4'h4;
    localparam logic [15:0] SYSCLK_KEY_FIRST = 16'h0046;
    localparam logic [15:0] SYSCLK_KEY_SECOND = 16'h0057;
    localparam int SYSCLK_CURRENT_SOURCE_FIELD_LSB = 12;
    localparam int SYSCLK_REQUESTED_OSC_FIELD_LSB = 8;
    localparam int SYSCLK_CLOCK_SWITCH_LOCK_BIT = 7;
    localparam int SYSCLK_PIN_ASSIGN_LOCK_BIT = 6;
    localparam int SYSCLK_PLLLOCK_BIT = 5;
    localparam int SYSCLK_FAIL_BIT = 3;
    localparam int SYSCLK_LPOSC_BIT = 1;
    localparam int SYSCLK_SWITCH_BIT = 0;
    localparam int SYSCLK_FAST_RC_POSTSCALE_LSB = 8;
    localparam logic [2:0] SYSCLK_FAST_RC_POSTSCALE_RESET = 3'h0;
    localparam logic [15:0] SYSCLK_PINSEL_RESET = 16'h1f1f;
    localparam logic [1:0] SYSCLK_SWITCH_MONITOR_CONFIG_SWONLY = 2'h1;
    localparam logic [2:0] SYSCLK_SRC_FRC = 3'h0;
    localparam logic [2:0] SYSCLK_SRC_FAST_RC_WITH_PLL = 3'h1;
    localparam logic [2:0] SYSCLK_SRC_PRI = 3'h2;
    localparam logic [2:0] SYSCLK_SRC_PRIPLL = 3'h3;
    localparam logic [2:0] SYSCLK_SRC_SEC = 3'h4;
    localparam logic [2:0] SYSCLK_SRC_LOW_POWER_RC_OSC = 3'h5;
    localparam logic [2:0] SYSCLK_SRC_FRC16 = 3'h6;
    localparam logic [2:0] SYSCLK_SRC_FRCN = 3'h7;
    localparam logic [1:0] SYSCLK_PRI_EC = 2'h0;
    localparam logic [1:0] SYSCLK_PRI_MS = 2'h1;
    localparam logic [1:0] SYSCLK_PRI_HS = 2'h2;
    localparam logic [1:0] SYSCLK_PRI_OFF = 2'h3;
    // unprogrammed configuration selects fast RC
    localparam logic [2:0] SYSCLK_CFG_DEFAULT = 3'h0;
    localparam int SYSCLK_MCLK_MHZ = 250;
    localparam int SYSCLK_PLL_START_US = 2;
    localparam int SYSCLK_PLL_START_CYC = SYSCLK_PLL_START_US * SYSCLK_MCLK_MHZ;
    localparam int SYSCLK_SWITCH_CYC = 8;
    localparam int SYSCLK_FCY_MAX_MHZ = 16;
    typedef enum logic [3:0] {
        SYSCLK_IDLE = 4'b0001,
        SYSCLK_KEY1 = 4'b0010,
        SYSCLK_OPEN = 4'b0100,
        SYSCLK_DONE = 4'b1000
    } sysclk_unlock_t;
    typedef enum logic [2:0] {
        SYSCLK_RUN = 3'b001,
        SYSCLK_WAIT = 3'b010,
        SYSCLK_SWAP = 3'b100
    } sysclk_switch_t;
endpackage

// ### hdl/sysclk_select_control.sv
// system clock source selection, switching, division and locks
`timescale 1ns/10ps
module sysclk_select_control
    import sysclk_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata,
    input wire logic [2:0] initialOscSelect,
    input wire logic [1:0] primaryModeSelect,
    input wire logic [1:0] switchMonitorConfig,
    input wire logic fastRcOsc,
    input wire logic primaryOsc,
    input wire logic secondaryOsc,
    input wire logic lowPowerRcOsc,
    input wire logic pllOut,
    input wire logic pllLockedRaw,
    output logic pllEnable,
    output logic [1:0] pllSourceSel,
    output logic wdtRefClk,
    output logic fscmRefClk,
    output logic oscillatorOutputClock,
    output logic instructionClock,
    output logic peripheralClock,
    output logic [2:0] clockMode,
    output logic [15:0] pinAssign
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic srcUsesPll(input logic [2:0] src);
        srcUsesPll = (src == SYSCLK_SRC_FAST_RC_WITH_PLL) || (src == SYSCLK_SRC_PRIPLL);
    endfunction

    function automatic logic isPllCross(input logic [2:0] a,
                                        input logic [2:0] b);
        isPllCross = ((a == SYSCLK_SRC_FAST_RC_WITH_PLL) && (b == SYSCLK_SRC_PRIPLL))
            || ((a == SYSCLK_SRC_PRIPLL) && (b == SYSCLK_SRC_FAST_RC_WITH_PLL));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin inputs: three flops, a change counts when stages two and three agree
    logic [5:0] syncA_q, syncB_q, syncC_q;
    logic [5:0] pinIn, pinStable_q;
    assign pinIn = {fastRcOsc, primaryOsc, secondaryOsc, lowPowerRcOsc,
                    pllOut, pllLockedRaw};
    always_ff @(posedge mclk)
    begin
        syncA_q <= pinIn;
        syncB_q <= syncA_q;
        syncC_q <= syncB_q;
    end
    always_ff @(posedge mclk)
    begin
        for (int i = 0; i < 6; i++)
        begin
            if (syncB_q[i] == syncC_q[i])
                pinStable_q[i] <= syncC_q[i];
        end
    end
    logic frcS, priS, secS, lprcS, pllS, pllLockS;
    assign {frcS, priS, secS, lprcS, pllS, pllLockS} = pinStable_q;

    ////////////////////////////////////////////////////////////////////////
    // register state
    logic [2:0] current_source_field_q, current_source_field_d;
    logic [2:0] requested_osc_field_q;
    logic clock_switch_lock_q, pin_assign_lock_q, lpOscEn_q, oswen_q, failFlag_q;
    logic [2:0] fast_rc_postscale_q;
    logic [15:0] pinAssign_q;
    logic cfgLoaded_q;
    sysclk_unlock_t unlock_q, unlock_d;
    sysclk_switch_t sw_q, sw_d;
    logic [3:0] swCnt_q;
    logic [9:0] pllCnt_q;
    logic pllStatus_q;

    // decoding of the configuration: 8 source codes from select and primary mode
    logic [2:0] cfgSrc;
    assign cfgSrc = ((initialOscSelect == SYSCLK_SRC_PRI
                      || initialOscSelect == SYSCLK_SRC_PRIPLL)
                     && primaryModeSelect == SYSCLK_PRI_OFF)
                    ? SYSCLK_CFG_DEFAULT : initialOscSelect;

    wire wrOsc = regWrite && (regAddr == SYSCLK_ADDR_OSCCTL);
    wire wrDiv = regWrite && (regAddr == SYSCLK_ADDR_CLOCK_DIVIDER_REG);
    wire wrKey = regWrite && (regAddr == SYSCLK_ADDR_UNLOCK);
    wire wrPin = regWrite && (regAddr == SYSCLK_ADDR_PINSEL);
    wire oscOpen = (unlock_q == SYSCLK_OPEN);
    wire oscWrOk = wrOsc && oscOpen;
    wire switchLocked = clock_switch_lock_q
        && (switchMonitorConfig == SYSCLK_SWITCH_MONITOR_CONFIG_SWONLY);
    wire switchReq = oswen_q && (sw_q == SYSCLK_RUN);
    wire switchRefused = isPllCross(current_source_field_q, requested_osc_field_q) || switchLocked;

    ////////////////////////////////////////////////////////////////////////
    // unlock sequence: two key words, then one write to the control reg
    always_comb
    begin
        unlock_d = unlock_q;
        case (unlock_q)
            SYSCLK_IDLE: if (wrKey && regWdata == SYSCLK_KEY_FIRST)
                unlock_d = SYSCLK_KEY1;
            SYSCLK_KEY1: if (wrKey && regWdata == SYSCLK_KEY_SECOND)
                unlock_d = SYSCLK_OPEN;
            else if (regWrite || regRead)
                unlock_d = SYSCLK_IDLE;
            SYSCLK_OPEN: if (regWrite || regRead)
                unlock_d = SYSCLK_DONE;
            SYSCLK_DONE: unlock_d = SYSCLK_IDLE;
            default: unlock_d = SYSCLK_IDLE;
        endcase
    end

    // switch engine: wait for the new source to settle, then swap
    always_comb
    begin
        sw_d = sw_q;
        current_source_field_d = current_source_field_q;
        case (sw_q)
            SYSCLK_RUN: if (switchReq && !switchRefused)
                sw_d = SYSCLK_WAIT;
            SYSCLK_WAIT: if (swCnt_q == 4'(SYSCLK_SWITCH_CYC - 1))
                sw_d = SYSCLK_SWAP;
            SYSCLK_SWAP:
            begin
                current_source_field_d = requested_osc_field_q;
                sw_d = SYSCLK_RUN;
            end
            default: sw_d = SYSCLK_RUN;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            unlock_q <= SYSCLK_IDLE;
            sw_q <= SYSCLK_RUN;
            swCnt_q <= 4'h0;
            cfgLoaded_q <= 1'b0;
        end
        else
        begin
            unlock_q <= unlock_d;
            sw_q <= sw_d;
            swCnt_q <= (sw_q == SYSCLK_WAIT) ? swCnt_q + 4'h1 : 4'h0;
            cfgLoaded_q <= 1'b1;
        end
    end

    // oscillator control register
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            current_source_field_q <= SYSCLK_CFG_DEFAULT;
            requested_osc_field_q <= SYSCLK_CFG_DEFAULT;
            clock_switch_lock_q <= 1'b0;
            pin_assign_lock_q <= 1'b0;
            lpOscEn_q <= 1'b0;
            oswen_q <= 1'b0;
            failFlag_q <= 1'b0;
        end
        else if (!cfgLoaded_q)
        begin
            current_source_field_q <= cfgSrc;
            requested_osc_field_q <= cfgSrc;
        end
        else
        begin
            current_source_field_q <= current_source_field_d;
            if (oscWrOk)
            begin
                requested_osc_field_q <= regWdata[SYSCLK_REQUESTED_OSC_FIELD_LSB +: 3];
                clock_switch_lock_q <= regWdata[SYSCLK_CLOCK_SWITCH_LOCK_BIT];
                pin_assign_lock_q <= regWdata[SYSCLK_PIN_ASSIGN_LOCK_BIT];
                lpOscEn_q <= regWdata[SYSCLK_LPOSC_BIT];
            end
            // request bit clears when the switch ends or is refused
            if (switchReq && switchRefused)
                oswen_q <= 1'b0;
            else if (oscWrOk && regWdata[SYSCLK_SWITCH_BIT])
                oswen_q <= 1'b1;
            else if (sw_q == SYSCLK_SWAP)
                oswen_q <= 1'b0;
            // refused switch sets the fail flag; set wins over clear
            if (switchReq && switchRefused)
                failFlag_q <= 1'b1;
            else if (oscWrOk && !regWdata[SYSCLK_FAIL_BIT])
                failFlag_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            fast_rc_postscale_q <= SYSCLK_FAST_RC_POSTSCALE_RESET;
            pinAssign_q <= SYSCLK_PINSEL_RESET;
        end
        else
        begin
            if (wrDiv)
                fast_rc_postscale_q <= regWdata[SYSCLK_FAST_RC_POSTSCALE_LSB +: 3];
            if (wrPin && !pin_assign_lock_q)
                pinAssign_q <= regWdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pll start-up timer and lock status
    wire pllOn = srcUsesPll(current_source_field_q) || srcUsesPll(requested_osc_field_q);
    // a refused cross request must not retarget a pll that is running
    wire [2:0] pllFeed = srcUsesPll(current_source_field_q) ? current_source_field_q : requested_osc_field_q;
    always_ff @(posedge mclk)
    begin
        if (rst || !pllOn)
        begin
            pllCnt_q <= 10'h000;
            pllStatus_q <= 1'b0;
        end
        else
        begin
            if (pllCnt_q != 10'(SYSCLK_PLL_START_CYC))
                pllCnt_q <= pllCnt_q + 10'h001;
            pllStatus_q <= pllLockS
                || (pllCnt_q == 10'(SYSCLK_PLL_START_CYC));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fast RC postscaler: divide by 2^(n+1), 1:2 .. 1:256
    logic [7:0] frcCnt_q;
    logic frcPrev_q;
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            frcCnt_q <= 8'h00;
            frcPrev_q <= 1'b0;
        end
        else
        begin
            frcPrev_q <= frcS;
            if (frcS && !frcPrev_q)
                frcCnt_q <= frcCnt_q + 8'h01;
        end
    end
    wire frcDivN = frcCnt_q[fast_rc_postscale_q];
    wire frcDiv16 = frcCnt_q[3];

    // source mux; pll output only for the two pll modes
    logic selClk;
    always_comb
    begin
        case (current_source_field_q)
            SYSCLK_SRC_FRC: selClk = frcS;
            SYSCLK_SRC_FAST_RC_WITH_PLL: selClk = pllS;
            SYSCLK_SRC_PRI: selClk = priS;
            SYSCLK_SRC_PRIPLL: selClk = pllS;
            SYSCLK_SRC_SEC: selClk = secS;
            SYSCLK_SRC_LOW_POWER_RC_OSC: selClk = lprcS;
            SYSCLK_SRC_FRC16: selClk = frcDiv16;
            default: selClk = frcDivN;
        endcase
    end

    // divide by two on each rising edge of the selected clock
    logic oscOut_q, selPrev_q, fcy_q;
    logic pllEn_q, wdt_q;
    logic [1:0] pllSrc_q;
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            oscOut_q <= 1'b0;
            selPrev_q <= 1'b0;
            fcy_q <= 1'b0;
            pllEn_q <= 1'b0;
            pllSrc_q <= 2'h0;
            wdt_q <= 1'b0;
        end
        else
        begin
            oscOut_q <= selClk;
            selPrev_q <= selClk;
            if (selClk && !selPrev_q)
                fcy_q <= !fcy_q;
            pllEn_q <= pllOn;
            // 01 fast RC, 10 primary, 00 none
            pllSrc_q <= (pllFeed == SYSCLK_SRC_FAST_RC_WITH_PLL) ? 2'h1 :
                        (pllFeed == SYSCLK_SRC_PRIPLL) ? 2'h2 : 2'h0;
            wdt_q <= lprcS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe
    wire [15:0] oscWord = {1'b0, current_source_field_q, 1'b0, requested_osc_field_q, clock_switch_lock_q, pin_assign_lock_q,
                           pllStatus_q, 1'b0, failFlag_q, 1'b0, lpOscEn_q,
                           oswen_q};
    logic [15:0] rdMux;
    always_comb
    begin
        if (regAddr == SYSCLK_ADDR_OSCCTL)
            rdMux = oscWord;
        else if (regAddr == SYSCLK_ADDR_CLOCK_DIVIDER_REG)
            rdMux = {5'h00, fast_rc_postscale_q, 8'h00};
        else if (regAddr == SYSCLK_ADDR_PINSEL)
            rdMux = pinAssign_q;
        else if (regAddr == SYSCLK_ADDR_STATUS)
            rdMux = {12'h000, sw_q != SYSCLK_RUN, oscOpen, pllEn_q, 1'b0};
        else
            rdMux = 16'h0000;
    end
    logic [15:0] rdata_q;
    always_ff @(posedge mclk)
    begin
        if (rst)
            rdata_q <= 16'h0000;
        else
            rdata_q <= regRead ? rdMux : 16'h0000;
    end

    assign regRdata = rdata_q;
    assign pllEnable = pllEn_q;
    assign pllSourceSel = pllSrc_q;
    assign wdtRefClk = wdt_q;
    assign fscmRefClk = wdt_q;
    assign oscillatorOutputClock = oscOut_q;
    assign instructionClock = fcy_q;
    assign peripheralClock = fcy_q;
    assign clockMode = current_source_field_q;
    assign pinAssign = pinAssign_q;

    ////////////////////////////////////////////////////////////////////////
    AST_LOCKED_WRITE: assert property (@(posedge mclk) disable iff (rst)
        (wrPin && pin_assign_lock_q) |=> $stable(pinAssign_q))
        else $error("pin assignment changed while locked");
    AST_OPEN_WRITE: assert property (@(posedge mclk) disable iff (rst)
        (wrPin && !pin_assign_lock_q) |=> pinAssign_q == $past(regWdata))
        else $error("pin assignment write lost");
    AST_UNLOCK: assert property (@(posedge mclk) disable iff (rst)
        (wrOsc && !oscOpen && cfgLoaded_q && sw_q == SYSCLK_RUN)
        |=> $stable(requested_osc_field_q))
        else $error("control written without unlock");
    AST_NO_CROSS: assert property (@(posedge mclk) disable iff (rst)
        (switchReq && isPllCross(current_source_field_q, requested_osc_field_q))
        |=> sw_q == SYSCLK_RUN && failFlag_q)
        else $error("pll to pll switch not refused");
    AST_CLOCK_SWITCH_LOCK: assert property (@(posedge mclk) disable iff (rst)
        (switchReq && switchLocked) |=> sw_q == SYSCLK_RUN)
        else $error("switch while clock locked");
    AST_SWITCH_DONE: assert property (@(posedge mclk) disable iff (rst)
        (sw_q == SYSCLK_RUN && sw_d == SYSCLK_WAIT)
        |-> ##10 current_source_field_q == $past(requested_osc_field_q, 9))
        else $error("switch did not complete");
    AST_RESERVED: assert property (@(posedge mclk) disable iff (rst)
        (regRead && regAddr == SYSCLK_ADDR_OSCCTL)
        |=> (regRdata & 16'h8814) == 16'h0000)
        else $error("unimplemented bit reads as one");
    AST_PLL_OFF: assert property (@(posedge mclk) disable iff (rst)
        !pllOn |=> !pllStatus_q)
        else $error("lock status high with pll off");
    AST_CFG_LOAD: assert property (@(posedge mclk)
        $fell(rst) |=> current_source_field_q == $past(cfgSrc) && requested_osc_field_q == current_source_field_q)
        else $error("power-on source not from configuration");
    COV_SWITCH: cover property (@(posedge mclk) disable iff (rst)
        sw_q == SYSCLK_SWAP);
    COV_REFUSE: cover property (@(posedge mclk) disable iff (rst)
        switchReq && switchRefused);
    COV_PINLOCK: cover property (@(posedge mclk) disable iff (rst)
        wrPin && pin_assign_lock_q);
    COV_PLLLOCK: cover property (@(posedge mclk) disable iff (rst)
        $rose(pllStatus_q));
endmodule

// ### bench/sysclk_osc_model.sv
// behavioural oscillators and pll on the far side of the clock select block
`timescale 1ns/10ps
module sysclk_osc_model
    import sysclk_pkg::*;
#(
    parameter int LOCK_CYC = 200
)
(
    input wire logic mclk,
    input wire logic pllEnable,
    input wire logic [1:0] pllSourceSel,
    output logic fastRcOsc,
    output logic primaryOsc,
    output logic secondaryOsc,
    output logic lowPowerRcOsc,
    output logic pllOut,
    output logic pllLockedRaw
);
    int lockCount = 0;
    initial
    begin
        fastRcOsc = 1'b0;
        primaryOsc = 1'b0;
        secondaryOsc = 1'b0;
        lowPowerRcOsc = 1'b0;
        pllOut = 1'b0;
    end
    // half periods off the system clock grid so sampling phase drifts
    always #48.3 fastRcOsc = ~fastRcOsc;
    always #40.7 primaryOsc = ~primaryOsc;
    always #88.1 secondaryOsc = ~secondaryOsc;
    always #104.9 lowPowerRcOsc = ~lowPowerRcOsc;
    // pll output stands low while not enabled
    always #24.1 pllOut = (pllEnable === 1'b1) ? ~pllOut : 1'b0;
    always @(posedge mclk)
    begin
        if (pllEnable !== 1'b1 || pllSourceSel === 2'b00)
            lockCount <= 0;
        else if (lockCount < LOCK_CYC)
            lockCount <= lockCount + 1;
    end
    assign pllLockedRaw = (lockCount >= LOCK_CYC);
endmodule

// ### bench/sysclk_select_control_bench.sv
// self-checking bench for the system clock select control block
`timescale 1ns/10ps
`define CHECK(nm, ex, gt) \
    begin \
        compares++; \
        if ((gt) !== (ex)) \
        begin \
            miscompares++; \
            $display("MISMATCH %s exp %h got %h", nm, ex, gt); \
        end \
    end
module sysclk_select_control_bench
    import sysclk_pkg::*;
;
    logic mclk, rst, regWrite, regRead;
    logic [3:0] regAddr;
    logic [15:0] regWdata;
    logic [2:0] initialOscSelect;
    logic [1:0] primaryModeSelect, switchMonitorConfig;
    wire logic [15:0] regRdata, pinAssign;
    wire logic [2:0] clockMode;
    wire logic [1:0] pllSourceSel;
    wire logic fastRcOsc, primaryOsc, secondaryOsc, lowPowerRcOsc;
    wire logic pllOut, pllLockedRaw, pllEnable, wdtRefClk, fscmRefClk;
    wire logic oscillatorOutputClock, instructionClock, peripheralClock;
    int miscompares = 0;
    int compares = 0;
    int fastRises = 0, outRises = 0, instRises = 0;
    int lprcRises = 0, wdtRises = 0, fscmRises = 0;
    logic [2:0] curCode;
    logic [2:0] seqCode [11] = '{3'h1, 3'h3, 3'h0, 3'h3, 3'h1, 3'h2,
        3'h4, 3'h5, 3'h6, 3'h7, 3'h0};
    bit seqRef [11] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0,
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    ////////////////////////////////////////////////////////////////////
    sysclk_select_control u_dut (.mclk(mclk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata),
        .initialOscSelect(initialOscSelect),
        .primaryModeSelect(primaryModeSelect),
        .switchMonitorConfig(switchMonitorConfig),
        .fastRcOsc(fastRcOsc), .primaryOsc(primaryOsc),
        .secondaryOsc(secondaryOsc), .lowPowerRcOsc(lowPowerRcOsc),
        .pllOut(pllOut), .pllLockedRaw(pllLockedRaw),
        .pllEnable(pllEnable), .pllSourceSel(pllSourceSel),
        .wdtRefClk(wdtRefClk), .fscmRefClk(fscmRefClk),
        .oscillatorOutputClock(oscillatorOutputClock),
        .instructionClock(instructionClock),
        .peripheralClock(peripheralClock), .clockMode(clockMode),
        .pinAssign(pinAssign));
    sysclk_osc_model u_osc (.mclk(mclk), .pllEnable(pllEnable),
        .pllSourceSel(pllSourceSel), .fastRcOsc(fastRcOsc),
        .primaryOsc(primaryOsc), .secondaryOsc(secondaryOsc),
        .lowPowerRcOsc(lowPowerRcOsc), .pllOut(pllOut),
        .pllLockedRaw(pllLockedRaw));
    always @(posedge fastRcOsc) fastRises++;
    always @(posedge oscillatorOutputClock) outRises++;
    always @(posedge instructionClock) instRises++;
    always @(posedge lowPowerRcOsc) lprcRises++;
    always @(posedge wdtRefClk) wdtRises++;
    always @(posedge fscmRefClk) fscmRises++;
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial
    begin
        #400000;
        miscompares++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_expired();
        miscompares++;
        end_of_test();
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask
    // two key writes and the control write on consecutive edges
    task automatic unlock_write(input logic [15:0] d);
        @(posedge mclk);
        regAddr <= SYSCLK_ADDR_UNLOCK;
        regWdata <= SYSCLK_KEY_FIRST;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWdata <= SYSCLK_KEY_SECOND;
        @(posedge mclk);
        regAddr <= SYSCLK_ADDR_OSCCTL;
        regWdata <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    task automatic cfg_reset(input logic [2:0] s, input logic [1:0] m);
        @(posedge mclk);
        initialOscSelect <= s;
        primaryModeSelect <= m;
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic poll(input int b, input logic v, output logic [15:0] d);
        int n;
        d = {16{~v}};
        for (n = 0; n < 1000 && d[b] !== v; n++)
            rd(SYSCLK_ADDR_OSCCTL, d);
        if (d[b] !== v)
            wait_expired();
    endtask
    task automatic sw(input logic [2:0] c, input logic [15:0] x, input bit r);
        logic [15:0] d;
        unlock_write({5'h00, c, 8'h01} | x);
        poll(SYSCLK_SWITCH_BIT, 1'b0, d);
        if (!r)
            curCode = c;
        `CHECK("currentSource", curCode, d[14:12]);
        `CHECK("failFlag", r, d[SYSCLK_FAIL_BIT]);
        `CHECK("clockMode", curCode, clockMode);
    endtask
    // counts reference rises between two rises of the divided clock
    task automatic span(input bit sel, output int diff);
        int start, base, n;
        for (int k = 0; k < 2; k++)
        begin
            start = sel ? instRises : outRises;
            base = sel ? outRises : fastRises;
            for (n = 0; n < 20000 && start == (sel ? instRises : outRises); n++)
            begin
                @(posedge mclk);
                #1;
            end
            if (n == 20000)
                wait_expired();
        end
        diff = (sel ? outRises : fastRises) - base;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [15:0] d;
        logic [2:0] e;
        logic [1:0] ps;
        int i, j, dl, dw, df;
        regAddr = 4'h0;
        regWdata = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        initialOscSelect = SYSCLK_CFG_DEFAULT;
        primaryModeSelect = SYSCLK_PRI_HS;
        switchMonitorConfig = SYSCLK_SWITCH_MONITOR_CONFIG_SWONLY;
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 8; i++)
            for (j = 0; j < 4; j++)
            begin
                cfg_reset(i[2:0], j[1:0]);
                e = (j == 3 && (i == 2 || i == 3)) ? SYSCLK_SRC_FRC : i[2:0];
                rd(SYSCLK_ADDR_OSCCTL, d);
                `CHECK("oscReset", {1'b0, e, 1'b0, e, 8'h00}, d);
                `CHECK("modeReset", e, clockMode);
            end
        `CHECK("pinReset", SYSCLK_PINSEL_RESET, pinAssign);
        cfg_reset(SYSCLK_CFG_DEFAULT, SYSCLK_PRI_HS);
        curCode = SYSCLK_SRC_FRC;
        wr(SYSCLK_ADDR_OSCCTL, 16'h0240);
        rd(SYSCLK_ADDR_OSCCTL, d);
        `CHECK("lockedWrite", 16'h0000, d);
        rd(4'hf, d);
        `CHECK("unmapped", 16'h0000, d);
        for (i = 0; i < 11; i++)
        begin
            sw(seqCode[i], 16'h0000, seqRef[i]);
            ps = (curCode == SYSCLK_SRC_FAST_RC_WITH_PLL) ? 2'b01 : 2'b10;
            case (curCode)
                SYSCLK_SRC_FAST_RC_WITH_PLL, SYSCLK_SRC_PRIPLL:
                begin
                    poll(SYSCLK_PLLLOCK_BIT, 1'b1, d);
                    `CHECK("pllSource", ps, pllSourceSel);
                    `CHECK("pllOn", 1'b1, pllEnable);
                end
                SYSCLK_SRC_SEC:
                begin
                    poll(SYSCLK_PLLLOCK_BIT, 1'b0, d);
                    `CHECK("pllOff", 1'b0, pllEnable);
                    `CHECK("pllNone", 2'b00, pllSourceSel);
                end
                SYSCLK_SRC_FRC16:
                begin
                    span(1'b0, df);
                    `CHECK("div16", 16, df);
                end
                SYSCLK_SRC_FRCN:
                begin
                    span(1'b0, df);
                    `CHECK("postscale2", 2, df);
                    wr(SYSCLK_ADDR_CLOCK_DIVIDER_REG, 16'h0700);
                    rd(SYSCLK_ADDR_CLOCK_DIVIDER_REG, d);
                    `CHECK("clock_divider_reg", 16'h0700, d);
                    span(1'b0, df);
                    `CHECK("postscale256", 256, df);
                    span(1'b1, df);
                    `CHECK("instDiv", 2, df);
                    `CHECK("periph", instructionClock, peripheralClock);
                end
                default: ;
            endcase
        end
        unlock_write({5'h00, curCode, 8'h80});
        sw(SYSCLK_SRC_PRI, 16'h0080, 1'b1);
        // the lock only blocks under the switching-only monitor setting
        switchMonitorConfig <= 2'h0;
        sw(SYSCLK_SRC_PRI, 16'h0080, 1'b0);
        switchMonitorConfig <= SYSCLK_SWITCH_MONITOR_CONFIG_SWONLY;
        unlock_write({5'h00, curCode, 8'h00});
        sw(SYSCLK_SRC_PRI, 16'h0000, 1'b0);
        sw(SYSCLK_SRC_FRC, 16'h0000, 1'b0);
        dl = lprcRises;
        dw = wdtRises;
        df = fscmRises;
        repeat (3000) @(posedge mclk);
        dl = lprcRises - dl;
        dw = wdtRises - dw;
        df = fscmRises - df;
        `CHECK("wdtRef", 1'b1, dl > 40 && dw - dl <= 1 && dl - dw <= 1);
        `CHECK("fscmRef", dw, df);
        wr(SYSCLK_ADDR_PINSEL, 16'h0a05);
        rd(SYSCLK_ADDR_PINSEL, d);
        `CHECK("pinWrite", 16'h0a05, d);
        unlock_write({5'h00, curCode, 8'h40});
        wr(SYSCLK_ADDR_PINSEL, 16'h1113);
        `CHECK("pinLocked", 16'h0a05, pinAssign);
        rd(SYSCLK_ADDR_OSCCTL, d);
        `CHECK("pinLockBit", 1'b1, d[SYSCLK_PIN_ASSIGN_LOCK_BIT]);
        unlock_write({5'h00, curCode, 8'h00});
        wr(SYSCLK_ADDR_PINSEL, 16'h1113);
        `CHECK("pinOpen", 16'h1113, pinAssign);
        unlock_write(16'h8814);
        rd(SYSCLK_ADDR_OSCCTL, d);
        `CHECK("unusedBits", 16'h0000, d);
        end_of_test();
    end
endmodule
